// ===== hdl/drive_ctl_pkg.sv
// package for the drive control/status word block
// shared register offsets, field positions, reset values and types
package drive_ctl_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL_WORD = 8'h00;
  localparam logic [7:0] OFF_REFERENCE = 8'h04;
  localparam logic [7:0] OFF_STATUS_WORD = 8'h08;
  localparam logic [7:0] OFF_OUT_FREQ = 8'h0c;
  localparam logic [7:0] OFF_CONFIG = 8'h10;
  localparam logic [7:0] OFF_DRIVE_IN = 8'h14;
  localparam logic [7:0] OFF_TIMEOUT = 8'h18;
  localparam logic [7:0] OFF_ACTIVE = 8'h1c;

  // control word bit positions
  localparam int CW_PRESET_LO = 0;
  localparam int CW_DC_BRAKE_N = 2;
  localparam int CW_COAST_N = 3;
  localparam int CW_QSTOP_N = 4;
  localparam int CW_FREEZE_N = 5;
  localparam int CW_START = 6;
  localparam int CW_RESET = 7;
  localparam int CW_JOG = 8;
  localparam int CW_VALID = 10;
  localparam int CW_RELAY1 = 11;
  localparam int CW_RELAY2 = 12;
  localparam int CW_SETUP_LO = 13;
  localparam int CW_REVERSE = 15;

  // status word bit positions
  localparam int SW_CTRL_READY = 0;
  localparam int SW_DRIVE_READY = 1;
  localparam int SW_STANDBY = 2;
  localparam int SW_TRIP = 3;
  localparam int SW_TRIP_LOCK = 6;
  localparam int SW_WARNING = 7;
  localparam int SW_AT_REF = 8;
  localparam int SW_SERIAL_OK = 9;
  localparam int SW_RUNNING = 11;

  // config register field positions
  localparam int CFG_START_SRC = 0;
  localparam int CFG_REV_SRC = 2;
  localparam int CFG_RELAY1_BUS = 4;
  localparam int CFG_RELAY2_BUS = 5;
  localparam int CFG_MULTI_SETUP = 6;

  // drive input register field positions
  localparam int DIN_TRIPPED = 0;
  localparam int DIN_TRIP_LOCK = 1;
  localparam int DIN_WARNING = 2;
  localparam int DIN_AT_REF = 3;
  localparam int DIN_LOCAL = 4;
  localparam int DIN_FREQ_NZ = 5;

  localparam logic [15:0] CTRL_RESET_VAL = 16'h0000;
  localparam logic [6:0] CONFIG_RESET_VAL = 7'h00;
  localparam logic [31:0] TIMEOUT_RESET_VAL = 32'h0098_9680;

  // gating of a bus bit with its terminal
  typedef enum logic [1:0] {
    SRC_DIGITAL,
    SRC_BUS,
    SRC_AND,
    SRC_OR
  } src_sel_t;

  // decoded commands toward the drive core
  typedef struct packed {
    logic [1:0] preset_sel;
    logic [1:0] setup_sel;
    logic dc_brake;
    logic coast;
    logic quick_stop;
    logic freeze;
    logic run;
    logic jog;
    logic reverse;
    logic trip_reset;
  } drive_cmd_t;

  // terminal levels seen by the block
  typedef struct packed {
    logic start;
    logic coast_n;
    logic dc_brake;
    logic reverse;
  } term_in_t;

endpackage

// ===== hdl/drive_control_status_word.sv
// drive control/status word interpreter with an apb register slave
// assumes terminal inputs synchronous to clk_sys; single clock domain
//
// Behaviour
// R1 - bits 1:0 choose one of four presets
// R2 - bit 2 low commands dc braking
// R3 - bit 3 low coasts; high allows start
// R4 - bit 4 low commands quick ramp stop
// R5 - bit 5 low freezes output frequency
// R6 - freeze ignores start-based stops only
// R7 - bit 6 run, gated with start terminal
// R8 - trip reset on bit 7 rising edge
// R9 - bit 8 selects jog frequency
// R10 - bit 10 low ignores whole word
// R11 - bits 11/12 drive relays when configured
// R12 - bus timeout drops bus-driven relays
// R13 - bits 14:13 choose setup if multi-setup
// R14 - bit 15 reverses per reversing source
// R15 - status 0 ready, 3 tripped
// R16 - status 1 ready but coasting held
// R17 - status 2 standby, awaiting start
// R18 - status 4 and 5 read zero
// R19 - status 6 shows trip lock
// R20 - status 7 shows warning
// R21 - status 8 speed equals reference
// R22 - status 9 serial control possible
// R23 - control then reference; status then frequency
// R24 - status 11 start or frequency nonzero
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps

module drive_control_status_word
  import drive_ctl_pkg::*;
#(
  parameter int TIMEOUT_W = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire term_in_t term,
  input wire logic [15:0] out_freq,
  output drive_cmd_t cmd,
  output logic relay1,
  output logic relay2,
  output logic [15:0] reference
);

  logic [15:0] ctrl_word;
  logic [15:0] next_ctrl_word;
  logic [15:0] next_reference;
  logic [6:0] config_reg;
  logic [6:0] next_config_reg;
  logic [5:0] drive_in;
  logic [5:0] next_drive_in;
  logic [TIMEOUT_W-1:0] timeout_lim;
  logic [TIMEOUT_W-1:0] next_timeout_lim;
  logic [TIMEOUT_W-1:0] idle_cnt;
  logic [TIMEOUT_W-1:0] next_idle_cnt;
  logic timed_out;
  logic next_timed_out;
  logic reset_prev;
  logic next_reset_prev;
  logic frozen;
  logic next_frozen;
  drive_cmd_t next_cmd;
  logic next_relay1;
  logic next_relay2;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [15:0] status_word;
  logic wr_fire;
  logic rd_fire;
  logic ctrl_take;
  src_sel_t start_src;
  src_sel_t rev_src;

  // access completes in the cycle after pready rises
  assign wr_fire = psel && penable && pwrite && pready;
  assign rd_fire = psel && penable && !pwrite && pready;
  assign start_src = src_sel_t'(config_reg[CFG_START_SRC +: 2]);
  assign rev_src = src_sel_t'(config_reg[CFG_REV_SRC +: 2]);

  function automatic logic gate(src_sel_t s, logic bus_b, logic term_b);
    logic r;
    r = 1'b0;
    case (s)
      SRC_DIGITAL: r = term_b;
      SRC_BUS: r = bus_b;
      SRC_AND: r = bus_b & term_b;
      SRC_OR: r = bus_b | term_b;
      default: r = term_b;
    endcase
    return r;
  endfunction

  // status word composition
  always_comb begin
    status_word = 16'h0000;
    status_word[SW_CTRL_READY] = !drive_in[DIN_TRIPPED]; // [R15]
    status_word[SW_TRIP] = drive_in[DIN_TRIPPED]; // [R15]
    status_word[SW_DRIVE_READY] = !drive_in[DIN_TRIPPED]
      && (cmd.coast || !term.coast_n); // [R16]
    status_word[SW_STANDBY] = !drive_in[DIN_TRIPPED] && !cmd.coast
      && !cmd.run && !drive_in[DIN_LOCAL]; // [R17]
    status_word[SW_TRIP_LOCK] = drive_in[DIN_TRIP_LOCK]; // [R19]
    status_word[SW_WARNING] = drive_in[DIN_WARNING]; // [R20]
    status_word[SW_AT_REF] = drive_in[DIN_AT_REF]; // [R21]
    status_word[SW_SERIAL_OK] = !drive_in[DIN_LOCAL]; // [R22]
    status_word[SW_RUNNING] = cmd.run || drive_in[DIN_FREQ_NZ]; // [R24]
  end // bits 4 and 5 stay zero [R18]

  // register file
  always_comb begin
    next_ctrl_word = ctrl_word;
    next_reference = reference;
    next_config_reg = config_reg;
    next_drive_in = drive_in;
    next_timeout_lim = timeout_lim;
    ctrl_take = 1'b0;
    if (wr_fire) begin
      case (paddr)
        OFF_CTRL_WORD: begin
          // local operation refuses serial commands [R22]
          if (pwdata[CW_VALID] && !drive_in[DIN_LOCAL]) begin // [R10]
            next_ctrl_word = pwdata[15:0];
            ctrl_take = 1'b1;
          end
        end
        OFF_REFERENCE: begin
          if (!drive_in[DIN_LOCAL]) begin
            next_reference = pwdata[15:0]; // [R23]
          end
        end
        OFF_CONFIG: next_config_reg = pwdata[6:0];
        OFF_DRIVE_IN: next_drive_in = pwdata[5:0];
        OFF_TIMEOUT: next_timeout_lim = pwdata[TIMEOUT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_word <= CTRL_RESET_VAL;
      reference <= 16'h0000;
      config_reg <= CONFIG_RESET_VAL;
      drive_in <= 6'h00;
      timeout_lim <= TIMEOUT_RESET_VAL[TIMEOUT_W-1:0];
    end else begin
      ctrl_word <= next_ctrl_word;
      reference <= next_reference;
      config_reg <= next_config_reg;
      drive_in <= next_drive_in;
      timeout_lim <= next_timeout_lim;
    end
  end

  // bus timeout watchdog, restarted by each accepted control word
  always_comb begin
    next_idle_cnt = idle_cnt;
    next_timed_out = timed_out;
    if (ctrl_take) begin
      next_idle_cnt = '0;
      next_timed_out = 1'b0;
    end else if (timeout_lim != '0 && !timed_out) begin
      if (idle_cnt >= timeout_lim - 1'b1) begin
        next_timed_out = 1'b1; // [R12]
      end else begin
        next_idle_cnt = idle_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idle_cnt <= '0;
      timed_out <= 1'b0;
    end else begin
      idle_cnt <= next_idle_cnt;
      timed_out <= next_timed_out;
    end
  end

  // command decode
  always_comb begin
    logic run_req;
    logic hard_stop;
    run_req = gate(start_src, ctrl_word[CW_START], term.start); // [R7]
    hard_stop = !ctrl_word[CW_COAST_N] || !term.coast_n
      || !ctrl_word[CW_DC_BRAKE_N] || term.dc_brake;
    next_cmd.preset_sel = ctrl_word[CW_PRESET_LO +: 2]; // [R1]
    next_cmd.setup_sel = config_reg[CFG_MULTI_SETUP]
      ? ctrl_word[CW_SETUP_LO +: 2] : 2'b00; // [R13]
    next_cmd.dc_brake = !ctrl_word[CW_DC_BRAKE_N] || term.dc_brake; // [R2]
    next_cmd.coast = !ctrl_word[CW_COAST_N]; // [R3]
    next_cmd.quick_stop = !ctrl_word[CW_QSTOP_N]; // [R4]
    next_frozen = !ctrl_word[CW_FREEZE_N]; // [R5]
    next_cmd.freeze = next_frozen;
    next_cmd.jog = ctrl_word[CW_JOG]; // [R9]
    next_cmd.reverse = gate(rev_src, ctrl_word[CW_REVERSE],
      term.reverse); // [R14]
    // a freeze holds the run command against start-based stops
    if (hard_stop) begin
      next_cmd.run = 1'b0; // [R3] [R6]
    end else if (frozen && next_frozen && cmd.run) begin
      next_cmd.run = 1'b1; // [R6]
    end else begin
      next_cmd.run = run_req;
    end
    next_reset_prev = ctrl_word[CW_RESET];
    next_cmd.trip_reset = ctrl_word[CW_RESET] && !reset_prev; // [R8]
    next_relay1 = config_reg[CFG_RELAY1_BUS] && ctrl_word[CW_RELAY1]
      && !timed_out; // [R11] [R12]
    next_relay2 = config_reg[CFG_RELAY2_BUS] && ctrl_word[CW_RELAY2]
      && !timed_out; // [R11] [R12]
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd <= '0;
      frozen <= 1'b0;
      reset_prev <= 1'b0;
      relay1 <= 1'b0;
      relay2 <= 1'b0;
    end else begin
      cmd <= next_cmd;
      frozen <= next_frozen;
      reset_prev <= next_reset_prev;
      relay1 <= next_relay1;
      relay2 <= next_relay2;
    end
  end

  // apb slave: one wait state, then pready for one cycle
  always_comb begin
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (psel && penable && !pready) begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        OFF_CTRL_WORD: next_prdata = {16'h0000, ctrl_word};
        OFF_REFERENCE: next_prdata = {16'h0000, reference};
        OFF_STATUS_WORD: next_prdata = {16'h0000, status_word};
        OFF_OUT_FREQ: next_prdata = {16'h0000, out_freq}; // [R23]
        OFF_CONFIG: next_prdata = {25'h0, config_reg};
        OFF_DRIVE_IN: next_prdata = {26'h0, drive_in};
        OFF_TIMEOUT: next_prdata = 32'(timeout_lim);
        OFF_ACTIVE: next_prdata = {20'h0_0000, cmd};
        default: next_pslverr = 1'b1;
      endcase
      if (pwrite) begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  a_reset_edge: assert property (@(posedge clk_sys) disable iff (rst)
    cmd.trip_reset |-> $past(ctrl_word[CW_RESET])
      && !$past(reset_prev)) // [R8]
    else $error("trip reset without rising edge");

  a_reset_single: assert property (@(posedge clk_sys) disable iff (rst)
    cmd.trip_reset |=> !cmd.trip_reset) // [R8]
    else $error("trip reset longer than one cycle");

  a_invalid_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_fire && paddr == OFF_CTRL_WORD && !pwdata[CW_VALID])
      |=> $stable(ctrl_word)) // [R10]
    else $error("invalid control word taken");

  a_coast_stops: assert property (@(posedge clk_sys) disable iff (rst)
    !rst && !ctrl_word[CW_COAST_N] |=> !cmd.run && cmd.coast) // [R3]
    else $error("coast did not stop run");

  a_relay_timeout: assert property (@(posedge clk_sys) disable iff (rst)
    timed_out |=> !relay1 && !relay2) // [R12]
    else $error("relay held after timeout");

  a_relay_config: assert property (@(posedge clk_sys) disable iff (rst)
    relay1 |-> $past(config_reg[CFG_RELAY1_BUS])
      && $past(ctrl_word[CW_RELAY1])) // [R11]
    else $error("relay 1 without control bit");

  a_preset_follow: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 cmd.preset_sel == $past(ctrl_word[1:0])) // [R1]
    else $error("preset selector mismatch");

  a_freeze_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (frozen && !ctrl_word[CW_FREEZE_N] && cmd.run && ctrl_word[CW_COAST_N]
      && term.coast_n && ctrl_word[CW_DC_BRAKE_N] && !term.dc_brake)
      |=> cmd.run) // [R6]
    else $error("frozen drive stopped by start");

  a_status_trip: assert property (@(posedge clk_sys) disable iff (rst)
    status_word[SW_TRIP] != status_word[SW_CTRL_READY]
      && status_word[5:4] == 2'b00) // [R15] [R18]
    else $error("trip and ready status clash");

  a_setup_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(config_reg[CFG_MULTI_SETUP]) |-> cmd.setup_sel == 2'b00) // [R13]
    else $error("setup selected without multi-setup");

endmodule

// ===== verification/apb_host.sv
// apb master model standing in for the serial bus master
// expects pready within 20 cycles of each access, else raises hung
`timescale 1ns/10ps
module apb_host (
  input wire logic clk_sys,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic hung
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata, hung} = '0;
    pstrb = 4'hf;
  end
  // r carries pslverr above the read data
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [32:0] r);
    int n;
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      hung = 1'b1;
    end
    r = {pslverr, prdata};
    {psel, penable} <= 2'b00;
    // released data lines show no stale value
    pwdata <= ~d;
  endtask
endmodule

// ===== verification/testbench.sv
// self-checking bench for the drive control/status word block
// assumes apb_host as bus master; model kept in logic vectors below
`timescale 1ns/10ps
module testbench;
  import drive_ctl_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, hung, relay1, relay2;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, x;
  logic [3:0] pstrb;
  logic [15:0] out_freq = 16'h0000;
  logic [15:0] reference;
  term_in_t term = 4'h4;
  drive_cmd_t cmd;
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] lfsr = 32'h0000_002f;
  logic [15:0] m_cw = 16'h0000;
  logic [6:0] m_cfg = 7'h00;
  logic [5:0] m_din = 6'h00;
  logic m_run = 1'b0;
  logic m_frz = 1'b0;
  logic [32:0] r;
  logic [15:0] seq [14] = '{16'h047c, 16'h045c, 16'h041c, 16'h0414,
    16'h047c, 16'h045c, 16'h0418, 16'h0400, 16'h0480, 16'h0480,
    16'h0401, 16'h2402, 16'h4483, 16'h6503};
  always #50 clk_sys = ~clk_sys;
  drive_control_status_word drive_control_status_word_i (.clk_sys, .rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .term, .out_freq, .cmd, .relay1, .relay2, .reference);
  apb_host apb_host_i (.clk_sys, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .hung);
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic gate(logic [1:0] s, logic b, logic t);
    return s == 2'd0 ? t : s == 2'd1 ? b : s == 2'd2 ? b & t : b | t;
  endfunction
  function automatic drive_cmd_t model();
    drive_cmd_t c;
    c = '0;
    c.preset_sel = m_cw[1:0];
    c.setup_sel = m_cfg[CFG_MULTI_SETUP] ? m_cw[14:13] : 2'b00;
    c.jog = m_cw[CW_JOG];
    c.dc_brake = !m_cw[2] || term.dc_brake;
    c.coast = !m_cw[3];
    c.quick_stop = !m_cw[4];
    c.freeze = !m_cw[5];
    c.reverse = gate(m_cfg[3:2], m_cw[15], term.reverse);
    // freeze holds run only when already frozen before this word
    c.run = gate(m_cfg[1:0], m_cw[6], term.start)
      || c.freeze && m_frz && m_run;
    c.run = c.run && !c.coast && term.coast_n && !c.dc_brake;
    return c;
  endfunction
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    apb_host_i.xfer(w, a, d, r);
    if (hung) begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic wctl(logic [15:0] cw);
    drive_cmd_t e;
    logic tr;
    bus(1'b1, OFF_CTRL_WORD, {16'h0000, cw});
    m_frz = !m_cw[CW_FREEZE_N];
    tr = 1'b0;
    if (cw[CW_VALID] && !m_din[DIN_LOCAL]) begin
      tr = cw[CW_RESET] && !m_cw[CW_RESET];
      m_cw = cw;
    end
    e = model();
    e.trip_reset = tr;
    m_run = e.run;
    @(posedge clk_sys);
    #1;
    cmp("cmd", {20'h0_0000, e}, {20'h0_0000, cmd});
    e.jog = m_cw[12] & m_cfg[5];
    e.reverse = m_cw[11] & m_cfg[4];
    cmp("relay", {30'h0, e.jog, e.reverse}, {30'h0, relay2, relay1});
  endtask
  task automatic chk();
    logic t;
    logic [15:0] s;
    t = m_din[DIN_TRIPPED];
    s = {4'h0, m_run | m_din[5], 1'b0, !m_din[4], m_din[3:1], 2'b00, t,
      !t & m_cw[3] & !m_run & !m_din[4], !t & (!m_cw[3] | !term.coast_n), !t};
    bus(1'b0, OFF_STATUS_WORD, 32'h0);
    cmp("status", {16'h0000, s}, r[31:0]);
    bus(1'b0, OFF_OUT_FREQ, 32'h0);
    cmp("freq", {16'h0000, out_freq}, r[31:0]);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    wctl(16'h0000);
    chk();
    bus(1'b0, OFF_TIMEOUT, 32'h0);
    cmp("timeout", TIMEOUT_RESET_VAL, r[31:0]);
    bus(1'b0, 8'h20, 32'h0);
    cmp("slverr", 32'h1, {31'h0, r[32]});
    bus(1'b1, OFF_TIMEOUT, 32'h0);
    repeat (40) begin
      x = rnd();
      m_cfg = x[6:0];
      m_din = x[12:7] & 6'h2f;
      term <= term_in_t'(x[16:13]);
      out_freq <= x[31:16];
      bus(1'b1, OFF_CONFIG, {25'h0, m_cfg});
      bus(1'b1, OFF_DRIVE_IN, {26'h0, m_din});
      x = rnd();
      wctl(x[15:0] | 16'h0030);
      bus(1'b1, OFF_REFERENCE, {16'h0000, x[31:16]});
      chk();
      cmp("reference", {16'h0, x[31:16]}, {16'h0, reference});
    end
    term <= 4'h4;
    m_din = 6'h00;
    bus(1'b1, OFF_DRIVE_IN, 32'h0);
    m_cfg = 7'h41;
    bus(1'b1, OFF_CONFIG, 32'h41);
    foreach (seq[i]) begin
      wctl(seq[i]);
    end
    m_din = 6'h10;
    bus(1'b1, OFF_DRIVE_IN, 32'h10);
    wctl(16'h047c);
    chk();
    m_din = 6'h00;
    bus(1'b1, OFF_DRIVE_IN, 32'h0);
    m_cfg = 7'h30;
    bus(1'b1, OFF_CONFIG, 32'h30);
    wctl(16'h1c00);
    bus(1'b1, OFF_TIMEOUT, 32'h14);
    repeat (40) @(posedge clk_sys);
    #1;
    cmp("relay_off", 32'h0, {30'h0, relay2, relay1});
    report_and_stop();
  end
endmodule
